// *** rtl/apo_pkg.sv ***
package apo_pkg;
    // width of one conversion result
    localparam int APO_CODE_W = 12;
    // edges from sampling to the result appearing on the output word
    localparam int APO_LATENCY = 7;
    // flops outside the delay line: capture flop and output flop
    localparam int APO_EDGE_FLOPS = 2;
    // inner stages of the delay line
    localparam int APO_PIPE_DEPTH = APO_LATENCY - APO_EDGE_FLOPS;
    // position of the sign bit of the quantiser result
    localparam int APO_SIGN_BIT = APO_CODE_W - 1;
    // offset binary landmarks
    localparam logic [APO_CODE_W-1:0] APO_CODE_MIDSCALE = 12'h800;
    localparam logic [APO_CODE_W-1:0] APO_CODE_TOP = 12'hfff;
    localparam logic [APO_CODE_W-1:0] APO_CODE_BOTTOM = 12'h000;
    // reset value of every code register
    localparam logic [APO_CODE_W-1:0] APO_CODE_RESET = 12'h000;

    // power state of the converter
    typedef enum logic [0:0] {
        APO_RUN = 1'b0,
        APO_SHUTDOWN = 1'b1
    } apo_power_t;
endpackage

// *** rtl/apo_pipe_if.sv ***
`timescale 1ns/1ps
// signals between the port logic and its delay line
interface apo_pipe_if #(
    parameter int W = 12
);
    logic [W-1:0] code_in;
    logic valid_in;
    logic advance;
    logic flush;
    logic [W-1:0] code_out;
    logic valid_out;

    modport feed (
        output code_in,
        output valid_in,
        output advance,
        output flush,
        input code_out,
        input valid_out
    );

    modport pipe (
        input code_in,
        input valid_in,
        input advance,
        input flush,
        output code_out,
        output valid_out
    );
endinterface

// *** rtl/apo_latency_pipe.sv ***
`timescale 1ns/1ps
// inner stages of the conversion pipeline
module apo_latency_pipe #(
    parameter int W = 12,
    parameter int DEPTH = 5
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    apo_pipe_if.pipe link
);
    logic [W-1:0] stage_code_q [DEPTH];
    logic [DEPTH-1:0] stage_valid_q;
    logic [W-1:0] stage_src [DEPTH];
    logic [DEPTH-1:0] valid_src;

    // stage inputs: first stage takes the capture flop, the rest chain
    assign stage_src[0] = link.code_in;
    assign valid_src[0] = link.valid_in;
    genvar i;
    generate
        for (i = 1; i < DEPTH; i++)
        begin : g_src
            assign stage_src[i] = stage_code_q[i-1];
            assign valid_src[i] = stage_valid_q[i-1];
        end
    endgenerate

    // one flop per stage; codes freeze and valids drop while flushed
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_stage
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stage_code_q[i] <= '0;
                    stage_valid_q[i] <= 1'b0;
                end
                else if (link.flush)
                begin
                    stage_valid_q[i] <= 1'b0;
                end
                else if (link.advance)
                begin
                    stage_code_q[i] <= stage_src[i];
                    stage_valid_q[i] <= valid_src[i];
                end
            end
        end
    endgenerate

    assign link.code_out = stage_code_q[DEPTH-1];
    assign link.valid_out = stage_valid_q[DEPTH-1];
endmodule

// *** rtl/apo_output_port.sv ***
`timescale 1ns/1ps
// Summary of operation
// - sample is taken on every rising clock edge while shutdown is low, which also advances the pipeline; falling edges do nothing.
// - result appears on the data outputs exactly seven clock cycles after sampling.
// - output enable high releases all twelve data lines; low drives them.
// - with outputs enabled and shutdown high, last code stays unchanged on outputs.
// - result is one twelve-bit word, bit 0 least significant, bit 11 most.
// - coding is offset binary; zero input gives midscale 1000 0000 0000.
module apo_output_port
    import apo_pkg::*;
#(
    parameter int CODE_W = APO_CODE_W,
    parameter int LATENCY = APO_LATENCY
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [CODE_W-1:0] quantized_sample,
    input wire logic output_enable_n,
    input wire logic shutdown_request,
    output logic [CODE_W-1:0] sample_code_bits,
    output logic sample_code_bits_oe,
    output logic code_valid,
    output logic powered_down
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int PIPE_DEPTH = LATENCY - APO_EDGE_FLOPS;

    logic [CODE_W-1:0] offset_code_w;
    logic running_w;
    logic [CODE_W-1:0] capture_q;
    logic capture_valid_q;
    logic [CODE_W-1:0] out_code_q;
    logic out_valid_q;
    logic oe_q;
    apo_power_t power_q;
    apo_power_t power_d;

    apo_pipe_if #(.W(CODE_W)) pipe_link ();

    ////////////////////////////////////////////////////////////////////////
    // decode

    // two's complement quantiser value to offset binary by flipping the sign
    assign offset_code_w = {~quantized_sample[APO_SIGN_BIT],
                            quantized_sample[APO_SIGN_BIT-1:0]};
    // converter runs whenever shutdown is not requested
    assign running_w = !shutdown_request;
    assign power_d = shutdown_request ? APO_SHUTDOWN : APO_RUN;

    ////////////////////////////////////////////////////////////////////////
    // power state

    // track whether the converter is in shutdown
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_q <= APO_RUN;
        end
        else
        begin
            case (power_d)
                APO_RUN: power_q <= APO_RUN;
                APO_SHUTDOWN: power_q <= APO_SHUTDOWN;
                default: power_q <= APO_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sampling

    // take a new sample on every rising edge while running
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            capture_q <= APO_CODE_RESET;
            capture_valid_q <= 1'b0;
        end
        else if (running_w)
        begin
            capture_q <= offset_code_w;
            capture_valid_q <= 1'b1;
        end
        else
        begin
            capture_valid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay line

    // inner stages move one place per running edge; shutdown flushes their valids
    assign pipe_link.code_in = capture_q;
    assign pipe_link.valid_in = capture_valid_q;
    assign pipe_link.advance = running_w;
    assign pipe_link.flush = shutdown_request;

    apo_latency_pipe #(
        .W(CODE_W),
        .DEPTH(PIPE_DEPTH)
    ) u_pipe (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .link(pipe_link)
    );

    ////////////////////////////////////////////////////////////////////////
    // output latch

    // last stage of the latency; holds the last code while shut down
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_code_q <= APO_CODE_RESET;
            out_valid_q <= 1'b0;
        end
        else if (running_w)
        begin
            out_code_q <= pipe_link.code_out;
            out_valid_q <= pipe_link.valid_out;
        end
        else
        begin
            out_valid_q <= 1'b0; // code frozen
        end
    end

    // driver enable follows the active-low enable input
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= !output_enable_n;
        end
    end

    // whole word on the bus, bit 0 is the lsb
    assign sample_code_bits = out_code_q;
    assign sample_code_bits_oe = oe_q;
    assign code_valid = out_valid_q;
    assign powered_down = (power_q == APO_SHUTDOWN);

    ////////////////////////////////////////////////////////////////////////
    // checks

    // a running edge loads the offset binary form of the input
    property p_capture;
        @(posedge sys_clk) disable iff (!reset_n)
        running_w |=> capture_q == $past(offset_code_w);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture flop missed the sample");

    // zero quantiser input lands on midscale
    property p_midscale;
        @(posedge sys_clk) disable iff (!reset_n)
        (running_w && quantized_sample == APO_CODE_BOTTOM)
            |=> capture_q == APO_CODE_MIDSCALE;
    endproperty
    a_midscale: assert property (p_midscale)
        else $error("zero input did not give midscale");

    // all-ones input, minus one lsb, gives 0111 1111 1111
    property p_extremes;
        @(posedge sys_clk) disable iff (!reset_n)
        (running_w && quantized_sample == APO_CODE_TOP)
            |=> capture_q == {1'b0, APO_CODE_TOP[APO_SIGN_BIT-1:0]};
    endproperty
    a_extremes: assert property (p_extremes)
        else $error("minus one lsb did not give 0111 1111 1111");

    // seven running edges bring a sample to the outputs
    sequence s_run7;
        running_w [*7];
    endsequence
    property p_latency;
        @(posedge sys_clk) disable iff (!reset_n)
        s_run7 |=> sample_code_bits == $past(offset_code_w, 7);
    endproperty
    a_latency: assert property (p_latency)
        else $error("output word not seven cycles after its sample");

    // bit order kept end to end: msb is the flipped sign
    property p_msb;
        @(posedge sys_clk) disable iff (!reset_n)
        s_run7 |=> sample_code_bits[APO_SIGN_BIT] ==
            !$past(quantized_sample[APO_SIGN_BIT], 7);
    endproperty
    a_msb: assert property (p_msb)
        else $error("msb of output word misplaced");

    // drivers released while enable is high, driven while low
    property p_release;
        @(posedge sys_clk) disable iff (!reset_n)
        output_enable_n |=> !sample_code_bits_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("outputs driven with enable high");

    property p_drive;
        @(posedge sys_clk) disable iff (!reset_n)
        !output_enable_n |=> sample_code_bits_oe;
    endproperty
    a_drive: assert property (p_drive)
        else $error("outputs not driven with enable low");

    // code frozen for the whole shutdown
    property p_freeze;
        @(posedge sys_clk) disable iff (!reset_n)
        shutdown_request |=> $stable(sample_code_bits);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("output code changed during shutdown");

    // after wake the first words are flagged invalid
    sequence s_wake;
        shutdown_request ##1 !shutdown_request;
    endsequence
    property p_wake;
        @(posedge sys_clk) disable iff (!reset_n)
        s_wake |=> !code_valid [*6];
    endproperty
    a_wake: assert property (p_wake)
        else $error("valid flag rose too early after shutdown");

    // seven running edges always give a valid word
    property p_valid;
        @(posedge sys_clk) disable iff (!reset_n)
        s_run7 |=> code_valid;
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid flag missing after seven running cycles");

endmodule

// *** tb/apo_capture_model.sv ***
`timescale 1ns/1ps
// downstream capture logic that reads the three-state code bus
module apo_capture_model
    import apo_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [APO_CODE_W-1:0] sample_code_bits,
    input wire logic sample_code_bits_oe,
    input wire logic code_valid,
    output logic [APO_CODE_W-1:0] bus_level,
    output logic [APO_CODE_W-1:0] captured_q
);
    logic [APO_CODE_W-1:0] last_q;

    // no pull on the lines: a released bus shows the inverse of its last value
    assign bus_level = sample_code_bits_oe ? sample_code_bits : ~last_q;

    ////////////////////////////////////////////////////////////////
    // remember the driven level, take only words marked valid
    always_ff @(posedge sys_clk)
    begin
        if (sample_code_bits_oe)
        begin
            last_q <= sample_code_bits;
        end
        if (code_valid && sample_code_bits_oe)
        begin
            captured_q <= bus_level;
        end
    end
endmodule

// *** tb/test_adc_parallel_output_port.sv ***
`timescale 1ns/1ps
module test_adc_parallel_output_port;
    import apo_pkg::*;
    logic sys_clk;
    logic reset_n;
    logic [11:0] quantized_sample;
    logic output_enable_n;
    logic shutdown_request;
    logic [11:0] sample_code_bits;
    logic sample_code_bits_oe;
    logic code_valid;
    logic powered_down;
    logic [11:0] bus_level;
    logic [11:0] captured_q;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // quantiser inputs and their offset binary words
    logic [11:0] smp [8] = '{12'h000, 12'h7ff, 12'h800, 12'h001, 12'hfff, 12'h7fe, 12'h801,
                             12'h2a5};
    logic [11:0] exp [8] = '{12'h800, 12'hfff, 12'h000, 12'h801, 12'h7ff, 12'hffe, 12'h001,
                             12'haa5};

    apo_output_port u_apo_output_port (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .quantized_sample(quantized_sample),
        .output_enable_n(output_enable_n),
        .shutdown_request(shutdown_request),
        .sample_code_bits(sample_code_bits),
        .sample_code_bits_oe(sample_code_bits_oe),
        .code_valid(code_valid),
        .powered_down(powered_down)
    );

    apo_capture_model u_apo_capture_model (
        .sys_clk(sys_clk),
        .sample_code_bits(sample_code_bits),
        .sample_code_bits_oe(sample_code_bits_oe),
        .code_valid(code_valid),
        .bus_level(bus_level),
        .captured_q(captured_q)
    );

    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////
    // shared compare and verdict
    task automatic check(input string what, input logic [11:0] e, input logic [11:0] got);
        checks_done++;
        if (got !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic run_reset();
        reset_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("reset code", 12'h000, sample_code_bits);
        check("reset valid", 12'h000, {11'h000, code_valid});
        check("reset oe", 12'h000, {11'h000, sample_code_bits_oe});
        check("reset state", 12'h000, {11'h000, powered_down});
        reset_n = 1'b1;
    endtask

    // back-to-back samples, one per edge, each word seven edges later
    task automatic run_stream();
        for (int i = 0; i < 15; i++)
        begin
            check("valid", {11'h000, i >= 7}, {11'h000, code_valid});
            // power state drops one edge after shutdown is released
            if (i > 0)
                check("run state", 12'h000, {11'h000, powered_down});
            if (i >= 7)
                check("code", exp[i - 7], sample_code_bits);
            quantized_sample = smp[i < 8 ? i : 7];
            @(negedge sys_clk);
        end
        check("captured", exp[7], captured_q);
    endtask

    // shutdown freezes the last word; enable still governs the bus
    task automatic run_shutdown();
        shutdown_request = 1'b1;
        quantized_sample = 12'h123;
        @(negedge sys_clk);
        for (int i = 0; i < 4; i++)
        begin
            check("held code", exp[7], sample_code_bits);
            check("sd valid", 12'h000, {11'h000, code_valid});
            check("sd state", 12'h001, {11'h000, powered_down});
            @(negedge sys_clk);
        end
        output_enable_n = 1'b1;
        @(negedge sys_clk);
        check("released oe", 12'h000, {11'h000, sample_code_bits_oe});
        check("released bus", ~exp[7], bus_level);
        output_enable_n = 1'b0;
        @(negedge sys_clk);
        check("driven oe", 12'h001, {11'h000, sample_code_bits_oe});
        check("driven bus", exp[7], bus_level);
        shutdown_request = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        quantized_sample = 12'h000;
        output_enable_n = 1'b0;
        shutdown_request = 1'b0;
        @(negedge sys_clk);
        run_reset();
        run_stream();
        run_shutdown();
        run_stream();
        conclude();
    end
endmodule
